// [rtl/bio_regs.sv]
// Board I/O address decoder, peripheral access timing and control registers.
//
// How it works
// - Serial channel A answers 60000000H-6000007EH and B 60000080H-600000FEH, byte wide, with a 70 ns hardware-timed access.
// - Accesses to the serial site and the parallel site windows are stretched by each site's ready input.
// - Byte peripherals and the serial site use the low 8 bits, control registers the low 4 bits, of 16-bit words at 2-byte steps.
// - The parallel site moves full 16-bit words on data lines 0 to 15 at 2-byte steps.
// - Any write to the kick register at 6006000EH restarts the watchdog, with a 100 ns hardware-timed access.
// - The watchdog enable register at 60060010H is a 4-bit read/write value cleared by reset.
// - The interrupt 4, 5, 6, 7 and non-maskable source selectors reset to 4H, 5H, 0H, 2H and FH.
// - The expansion site reset register at 60060012H is 4-bit read/write, cleared by reset.
// - Identity at 60060014H and boot mode at 60060016H are read-only and come from board straps.
// - The one board reset returns every register of this bank to its reset value together with the rest of the board.
`default_nettype none
module bio_regs
	import bio_pkg::*;
(
	// Clock and board reset.
	input wire logic i_mclk,
	input wire logic i_arst_n,
	// Asynchronous memory bus from the processor.
	input wire logic i_ce_n,
	input wire logic i_re_n,
	input wire logic i_we_n,
	input wire logic [31:0] i_addr,
	input wire logic [15:0] i_wdata,
	output logic [15:0] o_rdata,
	output logic o_rdata_oe,
	output logic o_ardy,
	// Peripheral side bus.
	output logic o_usart_a_cs_n,
	output logic o_usart_b_cs_n,
	output logic o_usb_cs_n,
	output logic o_rtc_cs_n,
	output logic o_serial_site_cs_n,
	output logic o_parallel_site_cs_n,
	output logic o_per_rd_n,
	output logic o_per_wr_n,
	output logic [15:0] o_per_addr,
	output logic [15:0] o_per_wdata,
	input wire logic [15:0] i_per_rdata,
	input wire logic i_serial_site_ready,
	input wire logic i_parallel_site_ready,
	// Board straps.
	input wire logic [3:0] i_board_identity,
	input wire logic [3:0] i_boot_mode,
	input wire logic [3:0] i_board_revision,
	// Control register outputs.
	output logic [3:0] o_int4_source_select,
	output logic [3:0] o_int5_source_select,
	output logic [3:0] o_int6_source_select,
	output logic [3:0] o_int7_source_select,
	output logic [3:0] o_nonmaskable_source_select,
	output logic [3:0] o_watchdog_enable,
	output logic [3:0] o_expansion_site_reset,
	output logic [3:0] o_system_configuration,
	output logic o_watchdog_kick
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: every bus pin is two flops deep before use.
	logic [68:0] sync1_reg;
	logic [68:0] sync2_reg;
	logic [68:0] pins;
	assign pins = {i_ce_n, i_re_n, i_we_n, i_addr, i_wdata, i_per_rdata,
		i_serial_site_ready, i_parallel_site_ready};
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync1_reg <= {3'h7, 66'h0};
			sync2_reg <= {3'h7, 66'h0};
		end else begin
			sync1_reg <= pins;
			sync2_reg <= sync1_reg;
		end
	end
	logic s_ce_n;
	logic s_re_n;
	logic s_we_n;
	logic [31:0] s_addr;
	logic [15:0] s_wdata;
	logic [15:0] s_per_rdata;
	logic s_sready;
	logic s_pready;
	assign {s_ce_n, s_re_n, s_we_n, s_addr, s_wdata, s_per_rdata,
		s_sready, s_pready} = sync2_reg;

	// Strap sync has no reset, so the straps are already through it when
	// the capture happens right after reset release.
	logic [11:0] st1_s_reg;
	logic [11:0] st2_s_reg;
	always_ff @(posedge i_mclk) begin
		st1_s_reg <= {i_board_identity, i_boot_mode, i_board_revision};
		st2_s_reg <= st1_s_reg;
	end

	////////////////////////////////////////////////////////////////////////
	// Window decode.
	function automatic logic hit(input logic [31:0] a, input logic [31:0] b,
		input logic [31:0] m);
		hit = (a & ~m) == b;
	endfunction : hit

	bio_target_t dec_tgt;
	logic [3:0] dec_cyc;
	always_comb begin
		dec_tgt = TGT_NONE;
		dec_cyc = MIN_CYC;
		if (hit(s_addr, USART_A_BASE, USART_MASK)) begin
			dec_tgt = TGT_USART_A;
			dec_cyc = USART_CYC + PER_SYNC_CYC;
		end else if (hit(s_addr, USART_B_BASE, USART_MASK)) begin
			dec_tgt = TGT_USART_B;
			dec_cyc = USART_CYC + PER_SYNC_CYC;
		end else if (hit(s_addr, USB_BASE, USB_MASK)) begin
			dec_tgt = TGT_USB;
			dec_cyc = USB_CYC + PER_SYNC_CYC;
		end else if (hit(s_addr, RTC_BASE, RTC_MASK)) begin
			dec_tgt = TGT_RTC;
			dec_cyc = RTC_CYC + PER_SYNC_CYC;
		end else if (hit(s_addr, SSITE_BASE, SSITE_MASK)) begin
			dec_tgt = TGT_SSITE;
		end else if (hit(s_addr, PSITE_BASE, PSITE_MASK)) begin
			dec_tgt = TGT_PSITE;
		end else if ({s_addr[31:1], 1'b0} == KICK_ADDR) begin
			dec_tgt = TGT_REGS;
			dec_cyc = KICK_CYC;
		end else if ((s_addr & ~32'h0000_001f) == INT4_SEL_ADDR) begin
			dec_tgt = TGT_REGS;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Access sequencer and registers.
	bio_state_t state_reg, state_next;
	bio_target_t tgt_reg, tgt_next;
	logic [3:0] cnt_reg, cnt_next;
	logic wr_reg, wr_next;
	logic [31:0] adr_reg, adr_next;
	logic [15:0] wd_reg, wd_next;
	logic [15:0] rd_reg, rd_next;
	logic strap_reg, strap_next;
	logic [3:0] ident_reg, ident_next;
	logic [3:0] boot_reg, boot_next;
	logic [3:0] rev_reg, rev_next;
	logic [3:0] i4_reg, i4_next;
	logic [3:0] i5_reg, i5_next;
	logic [3:0] i6_reg, i6_next;
	logic [3:0] i7_reg, i7_next;
	logic [3:0] nmi_reg, nmi_next;
	logic [3:0] wen_reg, wen_next;
	logic [3:0] xrst_reg, xrst_next;
	logic [3:0] cfg_reg, cfg_next;
	logic kick_reg, kick_next;

	logic start;
	logic [3:0] rv;
	logic [31:0] ra;
	assign start = !s_ce_n && (!s_re_n || !s_we_n);
	assign ra = {adr_reg[31:1], 1'b0};

	always_comb begin
		// Reads of the kick word and of unused words return zero.
		rv = 4'h0;
		unique case (ra)
			INT4_SEL_ADDR: rv = i4_reg;
			INT5_SEL_ADDR: rv = i5_reg;
			INT6_SEL_ADDR: rv = i6_reg;
			INT7_SEL_ADDR: rv = i7_reg;
			NMI_SEL_ADDR: rv = nmi_reg;
			WDOG_EN_ADDR: rv = wen_reg;
			XRST_ADDR: rv = xrst_reg;
			IDENT_ADDR: rv = ident_reg;
			BOOT_ADDR: rv = boot_reg;
			SYSCFG_ADDR: rv = cfg_reg;
			REVID_ADDR: rv = rev_reg;
			default: rv = 4'h0;
		endcase
	end

	always_comb begin
		state_next = state_reg;
		tgt_next = tgt_reg;
		cnt_next = cnt_reg;
		wr_next = wr_reg;
		adr_next = adr_reg;
		wd_next = wd_reg;
		rd_next = rd_reg;
		strap_next = 1'b1;
		ident_next = ident_reg;
		boot_next = boot_reg;
		rev_next = rev_reg;
		i4_next = i4_reg;
		i5_next = i5_reg;
		i6_next = i6_reg;
		i7_next = i7_reg;
		nmi_next = nmi_reg;
		wen_next = wen_reg;
		xrst_next = xrst_reg;
		cfg_next = cfg_reg;
		kick_next = 1'b0;
		// Straps are taken once, in the first cycle after reset release.
		if (!strap_reg) begin
			{ident_next, boot_next, rev_next} = st2_s_reg;
		end
		unique case (state_reg)
			ST_IDLE: begin
				if (start) begin
					state_next = ST_WAIT;
					tgt_next = dec_tgt;
					cnt_next = dec_cyc;
					wr_next = !s_we_n;
					adr_next = s_addr;
					wd_next = s_wdata;
				end
			end
			ST_WAIT: begin
				if (cnt_reg > MIN_CYC) begin
					cnt_next = cnt_reg - MIN_CYC;
				end else if ((tgt_reg == TGT_SSITE && !s_sready) ||
					(tgt_reg == TGT_PSITE && !s_pready)) begin
					cnt_next = MIN_CYC;
				end else begin
					state_next = ST_HOLD;
					rd_next = 16'h0;
					if (tgt_reg == TGT_PSITE) begin
						rd_next = s_per_rdata;
					end else if (tgt_reg == TGT_REGS) begin
						rd_next = {12'h0, rv};
					end else if (tgt_reg != TGT_NONE) begin
						rd_next = {8'h0, s_per_rdata[7:0]};
					end
					if (wr_reg && tgt_reg == TGT_REGS) begin
						unique case (ra)
							INT4_SEL_ADDR: i4_next = wd_reg[3:0];
							INT5_SEL_ADDR: i5_next = wd_reg[3:0];
							INT6_SEL_ADDR: i6_next = wd_reg[3:0];
							INT7_SEL_ADDR: i7_next = wd_reg[3:0];
							NMI_SEL_ADDR: nmi_next = wd_reg[3:0];
							KICK_ADDR: kick_next = 1'b1;
							WDOG_EN_ADDR: wen_next = wd_reg[3:0];
							XRST_ADDR: xrst_next = wd_reg[3:0];
							SYSCFG_ADDR: cfg_next = wd_reg[3:0];
							REVID_ADDR: rev_next = wd_reg[3:0];
							// Identity and boot mode keep their straps.
							default: kick_next = 1'b0;
						endcase
					end
				end
			end
			ST_HOLD: begin
				if (!start) begin
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_reg <= ST_IDLE;
			tgt_reg <= TGT_NONE;
			cnt_reg <= MIN_CYC;
			wr_reg <= 1'b0;
			adr_reg <= 32'h0;
			wd_reg <= 16'h0;
			rd_reg <= 16'h0;
			strap_reg <= 1'b0;
			ident_reg <= 4'h0;
			boot_reg <= 4'h0;
			rev_reg <= 4'h0;
			i4_reg <= INT4_SEL_RST;
			i5_reg <= INT5_SEL_RST;
			i6_reg <= INT6_SEL_RST;
			i7_reg <= INT7_SEL_RST;
			nmi_reg <= NMI_SEL_RST;
			wen_reg <= WDOG_EN_RST;
			xrst_reg <= XRST_RST;
			cfg_reg <= SYSCFG_RST;
			kick_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			tgt_reg <= tgt_next;
			cnt_reg <= cnt_next;
			wr_reg <= wr_next;
			adr_reg <= adr_next;
			wd_reg <= wd_next;
			rd_reg <= rd_next;
			strap_reg <= strap_next;
			ident_reg <= ident_next;
			boot_reg <= boot_next;
			rev_reg <= rev_next;
			i4_reg <= i4_next;
			i5_reg <= i5_next;
			i6_reg <= i6_next;
			i7_reg <= i7_next;
			nmi_reg <= nmi_next;
			wen_reg <= wen_next;
			xrst_reg <= xrst_next;
			cfg_reg <= cfg_next;
			kick_reg <= kick_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered pin drive. Ready stays low outside the hold phase so the
	// master never sees a stale high while the strobes are synchronised.
	logic [13:0] pin_reg, pin_next;
	logic busy_next;
	assign busy_next = state_next != ST_IDLE;
	always_comb begin
		pin_next = {12'hfff, 1'b0, 1'b0};
		pin_next[0] = state_next == ST_HOLD;
		pin_next[1] = state_next == ST_HOLD && !wr_next && start;
		pin_next[2] = !(busy_next && tgt_next == TGT_USART_A);
		pin_next[3] = !(busy_next && tgt_next == TGT_USART_B);
		pin_next[4] = !(busy_next && tgt_next == TGT_USB);
		pin_next[5] = !(busy_next && tgt_next == TGT_RTC);
		pin_next[6] = !(busy_next && tgt_next == TGT_SSITE);
		pin_next[7] = !(busy_next && tgt_next == TGT_PSITE);
		pin_next[8] = !(busy_next && !wr_next);
		pin_next[9] = !(busy_next && wr_next);
	end
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pin_reg <= {12'hfff, 1'b0, 1'b0};
		end else begin
			pin_reg <= pin_next;
		end
	end

	assign o_ardy = pin_reg[0];
	assign o_rdata_oe = pin_reg[1];
	assign o_rdata = rd_reg;
	assign o_usart_a_cs_n = pin_reg[2];
	assign o_usart_b_cs_n = pin_reg[3];
	assign o_usb_cs_n = pin_reg[4];
	assign o_rtc_cs_n = pin_reg[5];
	assign o_serial_site_cs_n = pin_reg[6];
	assign o_parallel_site_cs_n = pin_reg[7];
	assign o_per_rd_n = pin_reg[8];
	assign o_per_wr_n = pin_reg[9];
	// Word index: peripherals sit on 2-byte steps.
	assign o_per_addr = adr_reg[16:1];
	assign o_per_wdata = wd_reg;
	assign o_int4_source_select = i4_reg;
	assign o_int5_source_select = i5_reg;
	assign o_int6_source_select = i6_reg;
	assign o_int7_source_select = i7_reg;
	assign o_nonmaskable_source_select = nmi_reg;
	assign o_watchdog_enable = wen_reg;
	assign o_expansion_site_reset = xrst_reg;
	assign o_system_configuration = cfg_reg;
	assign o_watchdog_kick = kick_reg;

endmodule : bio_regs
`default_nettype wire

// [rtl/bio_pkg.sv]
// Constants, address map and types of the board I/O decode and control bank.
`default_nettype none
package bio_pkg;
	// Clock and hardware-timed access lengths.
	localparam int CLK_PERIOD_NS = 25;
	localparam int USART_ACCESS_NS = 70;
	localparam int USB_ACCESS_NS = 70;
	localparam int RTC_ACCESS_NS = 160;
	localparam int KICK_ACCESS_NS = 100;
	localparam int USART_CYC_I = (USART_ACCESS_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int USB_CYC_I = (USB_ACCESS_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int RTC_CYC_I = (RTC_ACCESS_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int KICK_CYC_I = (KICK_ACCESS_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam logic [3:0] USART_CYC = 4'(USART_CYC_I);
	localparam logic [3:0] USB_CYC = 4'(USB_CYC_I);
	localparam logic [3:0] RTC_CYC = 4'(RTC_CYC_I);
	localparam logic [3:0] KICK_CYC = 4'(KICK_CYC_I);
	localparam logic [3:0] MIN_CYC = 4'h1;
	// Peripheral read data crosses two sync flops, so timed peripheral accesses wait
	// this much longer before the data is taken.
	localparam logic [3:0] PER_SYNC_CYC = 4'h2;

	// Peripheral windows: base byte address and the mask of free low bits.
	localparam logic [31:0] USART_A_BASE = 32'h6000_0000;
	localparam logic [31:0] USART_B_BASE = 32'h6000_0080;
	localparam logic [31:0] USART_MASK = 32'h0000_007f;
	localparam logic [31:0] USB_BASE = 32'h6002_0000;
	localparam logic [31:0] USB_MASK = 32'h0000_003f;
	localparam logic [31:0] RTC_BASE = 32'h6004_0000;
	localparam logic [31:0] RTC_MASK = 32'h0000_007f;
	localparam logic [31:0] SSITE_BASE = 32'h6012_0000;
	localparam logic [31:0] SSITE_MASK = 32'h0000_007f;
	localparam logic [31:0] PSITE_BASE = 32'h6010_0000;
	localparam logic [31:0] PSITE_MASK = 32'h0001_ffff;

	// Control registers, one per 16-bit word.
	localparam logic [31:0] INT4_SEL_ADDR = 32'h6006_0000;
	localparam logic [31:0] INT5_SEL_ADDR = 32'h6006_0002;
	localparam logic [31:0] INT6_SEL_ADDR = 32'h6006_0004;
	localparam logic [31:0] INT7_SEL_ADDR = 32'h6006_0006;
	localparam logic [31:0] NMI_SEL_ADDR = 32'h6006_0008;
	localparam logic [31:0] KICK_ADDR = 32'h6006_000e;
	localparam logic [31:0] WDOG_EN_ADDR = 32'h6006_0010;
	localparam logic [31:0] XRST_ADDR = 32'h6006_0012;
	localparam logic [31:0] IDENT_ADDR = 32'h6006_0014;
	localparam logic [31:0] BOOT_ADDR = 32'h6006_0016;
	localparam logic [31:0] SYSCFG_ADDR = 32'h6006_0018;
	localparam logic [31:0] REVID_ADDR = 32'h6006_001a;

	// Reset values.
	localparam logic [3:0] INT4_SEL_RST = 4'h4;
	localparam logic [3:0] INT5_SEL_RST = 4'h5;
	localparam logic [3:0] INT6_SEL_RST = 4'h0;
	localparam logic [3:0] INT7_SEL_RST = 4'h2;
	localparam logic [3:0] NMI_SEL_RST = 4'hf;
	localparam logic [3:0] WDOG_EN_RST = 4'h0;
	localparam logic [3:0] XRST_RST = 4'h0;
	localparam logic [3:0] SYSCFG_RST = 4'h0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_HOLD = 3'b100
	} bio_state_t;

	typedef enum logic [2:0] {
		TGT_NONE = 3'h0,
		TGT_USART_A = 3'h1,
		TGT_USART_B = 3'h2,
		TGT_USB = 3'h3,
		TGT_RTC = 3'h4,
		TGT_SSITE = 3'h5,
		TGT_PSITE = 3'h6,
		TGT_REGS = 3'h7
	} bio_target_t;
endpackage : bio_pkg
`default_nettype wire

// [testbench/bio_regs_asserts.sv]
// Concurrent checks on the ports of the board I/O decode and control bank.
`default_nettype none
module bio_regs_checker (
	// Clock, reset and site inputs.
	input wire logic i_mclk,
	input wire logic i_arst_n,
	input wire logic i_serial_site_ready,
	input wire logic i_parallel_site_ready,
	// Bus and strobe outputs.
	input wire logic o_ardy,
	input wire logic o_rdata_oe,
	input wire logic o_watchdog_kick,
	input wire logic o_usart_a_cs_n,
	input wire logic o_usart_b_cs_n,
	input wire logic o_serial_site_cs_n,
	input wire logic o_parallel_site_cs_n,
	input wire logic [15:0] o_per_addr,
	// Register outputs.
	input wire logic [3:0] o_int4_source_select,
	input wire logic [3:0] o_int5_source_select,
	input wire logic [3:0] o_int6_source_select,
	input wire logic [3:0] o_int7_source_select,
	input wire logic [3:0] o_nonmaskable_source_select,
	input wire logic [3:0] o_watchdog_enable,
	input wire logic [3:0] o_expansion_site_reset
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_arst_n);
	////////////////////////////////////////////////////////////////////////
	property p_kick_pulse;
		o_watchdog_kick |=> !o_watchdog_kick;
	endproperty
	a_kick_pulse: assert property (p_kick_pulse)
		else $error("kick pulse longer than one cycle");
	property p_kick_ardy;
		$rose(o_watchdog_kick) |-> $rose(o_ardy);
	endproperty
	a_kick_ardy: assert property (p_kick_ardy)
		else $error("kick pulse not tied to the end of its access");
	// Channel A must hold the master off for the 70 ns access time.
	property p_usart_wait;
		$fell(o_usart_a_cs_n) |-> !o_ardy [*2] ##[1:4] o_ardy;
	endproperty
	a_usart_wait: assert property (p_usart_wait)
		else $error("serial channel access time wrong");
	property p_usart_a_addr;
		!o_usart_a_cs_n |-> o_per_addr[15:6] == 10'h000;
	endproperty
	a_usart_a_addr: assert property (p_usart_a_addr)
		else $error("channel A selected outside its window");
	property p_usart_b_addr;
		!o_usart_b_cs_n |-> o_per_addr[15:6] == 10'h001;
	endproperty
	a_usart_b_addr: assert property (p_usart_b_addr)
		else $error("channel B selected outside its window");
	property p_sel_reset;
		$rose(i_arst_n) |-> o_int4_source_select == 4'h4 &&
			o_int5_source_select == 4'h5 && o_int6_source_select == 4'h0 &&
			o_int7_source_select == 4'h2 &&
			o_nonmaskable_source_select == 4'hf;
	endproperty
	a_sel_reset: assert property (p_sel_reset)
		else $error("selector reset values wrong");
	property p_ctl_reset;
		$rose(i_arst_n) |-> o_watchdog_enable == 4'h0 &&
			o_expansion_site_reset == 4'h0;
	endproperty
	a_ctl_reset: assert property (p_ctl_reset)
		else $error("enable or site reset not cleared");
	property p_ss_stretch;
		(!o_serial_site_cs_n && !i_serial_site_ready && !o_ardy) [*4]
			|=> !o_ardy;
	endproperty
	a_ss_stretch: assert property (p_ss_stretch)
		else $error("serial site access ended while not ready");
	property p_ps_stretch;
		(!o_parallel_site_cs_n && !i_parallel_site_ready && !o_ardy) [*4]
			|=> !o_ardy;
	endproperty
	a_ps_stretch: assert property (p_ps_stretch)
		else $error("parallel site access ended while not ready");
	property p_oe_ardy;
		o_rdata_oe |-> o_ardy;
	endproperty
	a_oe_ardy: assert property (p_oe_ardy)
		else $error("read data driven outside the answer");
endmodule : bio_regs_checker
bind bio_regs bio_regs_checker chk_u (.i_mclk, .i_arst_n,
	.i_serial_site_ready, .i_parallel_site_ready, .o_ardy, .o_rdata_oe,
	.o_watchdog_kick, .o_usart_a_cs_n, .o_usart_b_cs_n, .o_serial_site_cs_n,
	.o_parallel_site_cs_n, .o_per_addr, .o_int4_source_select,
	.o_int5_source_select, .o_int6_source_select, .o_int7_source_select,
	.o_nonmaskable_source_select, .o_watchdog_enable,
	.o_expansion_site_reset);
`default_nettype wire

// [testbench/bio_master_model.sv]
// Processor side asynchronous bus master that runs one access at a time.
`default_nettype none
module bio_master_model (
	// Clock and answer.
	input wire logic i_mclk,
	input wire logic i_ardy,
	input wire logic [15:0] i_rdata,
	// Request.
	output logic o_ce_n,
	output logic o_re_n,
	output logic o_we_n,
	output logic [31:0] o_addr,
	output logic [15:0] o_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_ce_n = 1'b1;
		o_re_n = 1'b1;
		o_we_n = 1'b1;
		o_addr = 32'h0000_0000;
		o_wdata = 16'h0000;
	end
	// The memory interface setup, its clock select and its wait totals are
	// taken as done before the first access.
	// Released lines show the inverse so stale values cannot pass as valid.
	task automatic access(input logic [31:0] a, input logic wr,
		input logic [15:0] d, output logic [15:0] q, output logic ok);
		int n;
		@(posedge i_mclk);
		o_ce_n <= 1'b0;
		o_re_n <= wr;
		o_we_n <= !wr;
		o_addr <= a;
		o_wdata <= d;
		n = 0;
		do begin
			@(posedge i_mclk);
			n++;
		end while (i_ardy !== 1'b1 && n < 400);
		q = i_rdata;
		ok = (n < 400);
		o_ce_n <= 1'b1;
		o_re_n <= 1'b1;
		o_we_n <= 1'b1;
		o_addr <= ~a;
		o_wdata <= ~d;
		n = 0;
		while (i_ardy !== 1'b0 && n < 20) begin
			@(posedge i_mclk);
			n++;
		end
		repeat (4) @(posedge i_mclk);
	endtask : access
endmodule : bio_master_model
`default_nettype wire

// [testbench/tb_bio_regs.sv]
// Self-checking bench of the board I/O decode and control bank.
`default_nettype none
module tb_bio_regs
	import bio_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [31:0] a;
		logic wr;
		logic [15:0] d;
		logic [15:0] e;
	} bio_row_t;
	logic mclk, arst_n, ce_n, re_n, we_n, oe, ardy, kick, rd_n, wr_n, hold;
	logic ss_rdy = 1'b0;
	logic ps_rdy = 1'b0;
	logic [31:0] addr;
	logic [15:0] wdata, rdata, per_addr, per_wdata;
	logic [15:0] per_rdata = 16'hc3a5;
	logic [5:0] cs_n;
	logic [3:0] regs [8];
	int mismatches = 0;
	int n_compared = 0;
	int kicks = 0;
	bio_row_t rows [28] = '{
		{SYSCFG_ADDR, 1'b0, 16'h0000, 16'h0000},
		{SYSCFG_ADDR, 1'b1, 16'h0005, 16'h0000},
		{SYSCFG_ADDR, 1'b0, 16'h0000, 16'h0005},
		{REVID_ADDR, 1'b0, 16'h0000, 16'h0003},
		{USB_BASE | 32'h3e, 1'b0, 16'h0000, 16'h00a5},
		{RTC_BASE, 1'b0, 16'h0000, 16'h00a5},
		{INT4_SEL_ADDR, 1'b0, 16'h0000, 16'h0004},
		{INT5_SEL_ADDR, 1'b0, 16'h0000, 16'h0005},
		{INT6_SEL_ADDR, 1'b0, 16'h0000, 16'h0000},
		{INT7_SEL_ADDR, 1'b0, 16'h0000, 16'h0002},
		{NMI_SEL_ADDR, 1'b0, 16'h0000, 16'h000f},
		{WDOG_EN_ADDR, 1'b0, 16'h0000, 16'h0000},
		{XRST_ADDR, 1'b0, 16'h0000, 16'h0000},
		{WDOG_EN_ADDR, 1'b1, 16'hfff9, 16'h0000},
		{WDOG_EN_ADDR, 1'b0, 16'h0000, 16'h0009},
		{XRST_ADDR, 1'b1, 16'h0036, 16'h0000},
		{XRST_ADDR, 1'b0, 16'h0000, 16'h0006},
		{INT6_SEL_ADDR, 1'b1, 16'h000a, 16'h0000},
		{INT6_SEL_ADDR, 1'b0, 16'h0000, 16'h000a},
		{IDENT_ADDR, 1'b1, 16'h0005, 16'h0000},
		{IDENT_ADDR, 1'b0, 16'h0000, 16'h000a},
		{BOOT_ADDR, 1'b0, 16'h0000, 16'h0006},
		{KICK_ADDR, 1'b0, 16'h0000, 16'h0000},
		{32'h6006_0020, 1'b0, 16'h0000, 16'h0000},
		{USART_A_BASE | 32'h7e, 1'b0, 16'h0000, 16'h00a5},
		{USART_B_BASE, 1'b0, 16'h0000, 16'h00a5},
		{PSITE_BASE | 32'h1fffe, 1'b0, 16'h0000, 16'hc3a5},
		{SSITE_BASE | 32'h7e, 1'b0, 16'h0000, 16'h00a5}
	};
	logic [3:0] rst_val [8] = '{4'h4, 4'h5, 4'h0, 4'h2, 4'hf, 4'h0, 4'h0,
		4'h0};
	bio_regs dut_u (.i_mclk(mclk), .i_arst_n(arst_n), .i_ce_n(ce_n),
		.i_re_n(re_n), .i_we_n(we_n), .i_addr(addr), .i_wdata(wdata),
		.o_rdata(rdata), .o_rdata_oe(oe), .o_ardy(ardy),
		.o_usart_a_cs_n(cs_n[0]), .o_usart_b_cs_n(cs_n[1]),
		.o_usb_cs_n(cs_n[2]), .o_rtc_cs_n(cs_n[3]),
		.o_serial_site_cs_n(cs_n[4]), .o_parallel_site_cs_n(cs_n[5]),
		.o_per_rd_n(rd_n), .o_per_wr_n(wr_n), .o_per_addr(per_addr),
		.o_per_wdata(per_wdata), .i_per_rdata(per_rdata),
		.i_serial_site_ready(ss_rdy), .i_parallel_site_ready(ps_rdy),
		.i_board_identity(4'ha), .i_boot_mode(4'h6),
		.i_board_revision(4'h3), .o_int4_source_select(regs[0]),
		.o_int5_source_select(regs[1]), .o_int6_source_select(regs[2]),
		.o_int7_source_select(regs[3]),
		.o_nonmaskable_source_select(regs[4]),
		.o_watchdog_enable(regs[5]), .o_expansion_site_reset(regs[6]),
		.o_system_configuration(regs[7]), .o_watchdog_kick(kick));
	bio_master_model bm_u (.i_mclk(mclk), .i_ardy(ardy), .i_rdata(rdata),
		.o_ce_n(ce_n), .o_re_n(re_n), .o_we_n(we_n), .o_addr(addr),
		.o_wdata(wdata));
	////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// Peripherals drive data only while selected; sites turn ready late.
	always @(posedge mclk) begin
		per_rdata <= (&cs_n) ? ~per_rdata : 16'hc3a5;
		ss_rdy <= !cs_n[4] && !hold;
		ps_rdy <= !cs_n[5] && !hold;
		if (kick === 1'b1) kicks++;
	end
	task automatic check(input string nm, input logic [15:0] exp,
		input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	task automatic xfer(input logic [31:0] a, input logic wr,
		input logic [15:0] d, output logic [15:0] q);
		logic ok;
		bm_u.access(a, wr, d, q, ok);
		check("answer in time", 16'h1, {15'h0, ok});
	endtask : xfer
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out
	initial begin
		repeat (30000) @(posedge mclk);
		mismatches++;
		close_out();
	end
	initial begin
		logic [15:0] q;
		arst_n = 1'b0;
		hold = 1'b0;
		repeat (6) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		foreach (rows[i]) begin
			xfer(rows[i].a, rows[i].wr, rows[i].d, q);
			if (!rows[i].wr)
				check($sformatf("read %h", rows[i].a), rows[i].e, q);
		end
		check("kicks from read", 16'h0, 16'(kicks));
		xfer(KICK_ADDR, 1'b1, 16'h0000, q);
		xfer(KICK_ADDR, 1'b1, 16'hffff, q);
		check("kicks from writes", 16'h2, 16'(kicks));
		xfer(USART_B_BASE | 32'h2, 1'b1, 16'h1234, q);
		check("peripheral address", 16'h0041, per_addr);
		check("peripheral write data", 16'h1234, per_wdata);
		check("strobes idle", 16'h0003, {14'h0, wr_n, rd_n});
		check("selects idle", 16'h003f, {10'h0, cs_n});
		for (int s = 0; s < 2; s++) begin
			hold <= 1'b1;
			fork
				xfer(s ? PSITE_BASE : SSITE_BASE, 1'b0, 16'h0000, q);
				begin
					repeat (30) @(posedge mclk);
					check("ready held off", 16'h0, {15'h0, ardy});
					hold <= 1'b0;
				end
			join
			check("site data", s ? 16'hc3a5 : 16'h00a5, q);
		end
		check("enable level", 16'h9, {12'h0, regs[5]});
		@(posedge mclk);
		arst_n <= 1'b0;
		repeat (6) @(posedge mclk);
		for (int r = 0; r < 8; r++)
			check($sformatf("reset reg %0d", r), {12'h0, rst_val[r]}, {12'h0, regs[r]});
		arst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		xfer(INT6_SEL_ADDR, 1'b0, 16'h0000, q);
		check("selector after reset", 16'h0000, q);
		close_out();
	end
endmodule : tb_bio_regs
`default_nettype wire
